// ===== cfe_ctl_exec.sv
// Control-flow instruction executor
//
// Contract
// - Config load copies working register into config register, one cycle, flags untouched
// - Software reset instruction resets the device like a hardware reset, except the reset instruction flag, which it clears
// - Software reset instruction clears the reset instruction flag
// - Return from interrupt pops stack and loads top entry into program counter
// - Return from interrupt sets global interrupt enable, bit 7
// - Return from interrupt is one word, two cycles, no flags changed
// - Return pops stack, loads return address into program counter, flags untouched
// - Return takes two cycles, second refills the fetch path
`timescale 1ns/10ps
`default_nettype none
`include "cfe_defines.svh"

module cfe_ctl_exec #(
  parameter int PC_W  = 15,
  parameter int OPC_W = 14,
  parameter int DEPTH = `CFE_STACK_DEPTH,
  parameter int PW    = $clog2(DEPTH)
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             instr_valid,
  input  wire logic [OPC_W-1:0] instr_word,
  input  wire logic [7:0]       w_reg,
  input  wire logic             irq_take,
  input  wire logic             call_req,
  input  wire logic [PC_W-1:0]  call_target,
  input  wire logic             ri_flag_write,
  output logic      [PC_W-1:0]  program_counter,
  output logic      [7:0]       config_register,
  output logic      [7:0]       interrupt_control_register,
  output logic                  global_interrupt_enable,
  output logic                  reset_instruction_flag,
  output logic                  soft_reset,
  output logic                  busy
);
  import cfe_pkg::*;

  if (PC_W != 15 || OPC_W != 14) begin : g_chk
    $error("Program counter must be 15 bits and opcodes 14 bits");
  end

  localparam logic [7:0] INT_CTRL_RST = `CFE_INT_CTRL_RESET;

  cfe_state_type     state_q;
  logic              busy_q;
  logic [PC_W-1:0]   pc_q;
  logic [7:0]        cfg_q;
  logic              int_en_q;
  logic              ri_flag_q;
  logic              soft_reset_q;
  logic              core_rst;
  logic              go;
  logic              op_cfg;
  logic              op_srst;
  logic              op_ret;
  logic              op_reti;
  logic              take_irq;
  logic              take_call;
  logic              push;
  logic              pop;
  logic [PC_W-1:0]   push_data;
  logic [PC_W-1:0]   stack_top;
  logic [PW-1:0]     stack_ptr;

  assign core_rst = rst | soft_reset_q;

  // ************************************************
  // Decode
  // ************************************************
  always_comb begin
    take_irq  = (state_q == CFE_ST_EXEC) && !soft_reset_q && irq_take;
    take_call = (state_q == CFE_ST_EXEC) && !soft_reset_q && !irq_take && call_req;
    go        = (state_q == CFE_ST_EXEC) && !soft_reset_q && !irq_take && !call_req && instr_valid;
    op_cfg    = go && (instr_word == `CFE_OP_CONFIG_LOAD);
    op_srst   = go && (instr_word == `CFE_OP_SOFT_RESET);
    op_ret    = go && (instr_word == `CFE_OP_RETURN);
    op_reti   = go && (instr_word == `CFE_OP_RETURN_FROM_INT);
    push      = take_irq || take_call;
    pop       = op_ret || op_reti;
    push_data = take_irq ? pc_q : pc_q + PC_W'(1);
  end

  cfe_ret_stack #(
    .DEPTH     (DEPTH),
    .AW        (PC_W),
    .PW        (PW)
  ) u_stack (
    .clk       (clk),
    .rst       (core_rst),
    .push      (push),
    .pop       (pop),
    .push_data (push_data),
    .top       (stack_top),
    .ptr       (stack_ptr)
  );

  // ************************************************
  // Sequencer
  // ************************************************
  always_ff @(posedge clk) begin
    if (core_rst) begin
      state_q <= CFE_ST_EXEC;
    end else begin
      case (state_q)
        CFE_ST_EXEC: begin
          if (pop) begin
            state_q <= CFE_ST_FLUSH;
          end
        end
        CFE_ST_FLUSH: begin
          state_q <= CFE_ST_EXEC;
        end
        default: begin
          state_q <= CFE_ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (core_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= pop;
    end
  end

  // ************************************************
  // Program counter
  // ************************************************
  always_ff @(posedge clk) begin
    if (core_rst) begin
      pc_q <= `CFE_PC_RESET;
    end else if (take_irq) begin
      pc_q <= `CFE_INT_VECTOR;
    end else if (take_call) begin
      pc_q <= call_target;
    end else if (pop) begin
      pc_q <= stack_top;
    end else if (go) begin
      pc_q <= pc_q + PC_W'(1);
    end
  end

  // ************************************************
  // Configuration register
  // ************************************************
  always_ff @(posedge clk) begin
    if (core_rst) begin
      cfg_q <= `CFE_CONFIG_RESET;
    end else if (op_cfg) begin
      cfg_q <= w_reg;
    end
  end

  // ************************************************
  // Global interrupt enable
  // ************************************************
  always_ff @(posedge clk) begin
    if (core_rst) begin
      int_en_q <= INT_CTRL_RST[`CFE_INT_ENABLE_BIT];
    end else if (op_reti) begin
      int_en_q <= 1'b1;
    end else if (take_irq) begin
      int_en_q <= 1'b0;
    end
  end

  // ************************************************
  // Software reset and cause flag
  // ************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= op_srst;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ri_flag_q <= `CFE_RI_FLAG_RESET;
    end else if (op_srst) begin
      ri_flag_q <= 1'b0;
    end else if (ri_flag_write) begin
      ri_flag_q <= 1'b1;
    end
  end

  assign program_counter            = pc_q;
  assign config_register            = cfg_q;
  assign global_interrupt_enable    = int_en_q;
  assign interrupt_control_register = 8'(int_en_q) << `CFE_INT_ENABLE_BIT;
  assign reset_instruction_flag     = ri_flag_q;
  assign soft_reset                 = soft_reset_q;
  assign busy                       = busy_q;

  // ************************************************
  // Checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence flush_seq;
    busy ##1 !busy;
  endsequence

  sequence reset_seq;
    soft_reset ##1 (pc_q == `CFE_PC_RESET && !int_en_q && cfg_q == `CFE_CONFIG_RESET && !busy);
  endsequence

  cfg_load_a: assert property (op_cfg |=> cfg_q == $past(w_reg) && pc_q == $past(pc_q) + PC_W'(1) && !busy)
    else $error("Config load failed");
  soft_reset_a: assert property (op_srst |=> reset_seq)
    else $error("Soft reset did not reset the core");
  ri_clear_a: assert property (op_srst |=> !ri_flag_q ##1 !ri_flag_q)
    else $error("Reset cause flag not cleared");
  reti_pc_a: assert property (op_reti |=> pc_q == $past(stack_top))
    else $error("Interrupt return loaded wrong address");
  reti_int_en_a: assert property (op_reti |=> int_en_q && interrupt_control_register[`CFE_INT_ENABLE_BIT])
    else $error("Interrupt return left interrupts off");
  reti_cycles_a: assert property (op_reti |=> flush_seq)
    else $error("Interrupt return not two cycles");
  return_pc_a: assert property (op_ret |=> pc_q == $past(stack_top) && cfg_q == $past(cfg_q))
    else $error("Return loaded wrong address");
  return_flush_a: assert property (op_ret |=> flush_seq and (pc_q == $past(stack_top) ##1 $stable(pc_q)))
    else $error("Return refill cycle wrong");
  stack_pop_a: assert property (pop |=> stack_ptr == $past(stack_ptr) - PW'(1))
    else $error("Stack pointer not stepped back");

endmodule : cfe_ctl_exec

`default_nettype wire

// ===== cfe_defines.svh
// Constants for the control-flow instruction executor
`ifndef CFE_DEFINES_SVH
`define CFE_DEFINES_SVH

// ************************************************
// Opcodes
// ************************************************
`define CFE_OP_NO_OPERATION      14'h0000
`define CFE_OP_SOFT_RESET        14'h0001
`define CFE_OP_RETURN            14'h0008
`define CFE_OP_RETURN_FROM_INT   14'h0009
`define CFE_OP_CONFIG_LOAD       14'h0062

// ************************************************
// Reset values and positions
// ************************************************
`define CFE_PC_RESET             15'h0000
`define CFE_INT_VECTOR           15'h0004
`define CFE_CONFIG_RESET         8'hff
`define CFE_INT_ENABLE_BIT       7
`define CFE_INT_CTRL_RESET       8'h00
`define CFE_RI_FLAG_RESET        1'b1
`define CFE_STACK_DEPTH          16

`endif

// ===== cfe_pkg.sv
// Types for the control-flow instruction executor
`default_nettype none

package cfe_pkg;

  typedef enum logic [0:0] {
    CFE_ST_EXEC,
    CFE_ST_FLUSH
  } cfe_state_type;

endpackage : cfe_pkg

`default_nettype wire

// ===== cfe_ret_stack.sv
// Hardware return-address stack
`timescale 1ns/10ps
`default_nettype none

module cfe_ret_stack #(
  parameter int DEPTH = 16,
  parameter int AW    = 15,
  parameter int PW    = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          push,
  input  wire logic          pop,
  input  wire logic [AW-1:0] push_data,
  output logic      [AW-1:0] top,
  output logic      [PW-1:0] ptr
);

  logic [AW-1:0] mem_q [DEPTH];
  logic [PW-1:0] ptr_q;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("Stack depth must be a power of two");
  end

  // ************************************************
  // Storage
  // ************************************************
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[ptr_q] <= push_data;
    end
  end

  // ************************************************
  // Pointer
  // ************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q <= '0;
    end else if (push) begin
      ptr_q <= ptr_q + PW'(1);
    end else if (pop) begin
      ptr_q <= ptr_q - PW'(1);
    end
  end

  assign top = mem_q[ptr_q - PW'(1)];
  assign ptr = ptr_q;

endmodule : cfe_ret_stack

`default_nettype wire

// ===== cfe_tb.sv
// Self-checking testbench for the control-flow instruction executor
`timescale 1ns/10ps
`default_nettype none
`include "cfe_defines.svh"

module tb;
  import cfe_pkg::*;

  // ************************************************
  // Signals and design instance
  // ************************************************
  logic        clk;
  logic        rst;
  logic        instr_valid;
  logic [13:0] instr_word;
  logic [7:0]  w_reg;
  logic        irq_take;
  logic        call_req;
  logic [14:0] call_target;
  logic        ri_flag_write;
  logic [14:0] program_counter;
  logic [7:0]  config_register;
  logic [7:0]  interrupt_control_register;
  logic        global_interrupt_enable;
  logic        reset_instruction_flag;
  logic        soft_reset;
  logic        busy;
  int          err_total;
  int          samples_checked;
  int          cycles;

  cfe_ctl_exec DUT (
    .clk                        (clk),
    .rst                        (rst),
    .instr_valid                (instr_valid),
    .instr_word                 (instr_word),
    .w_reg                      (w_reg),
    .irq_take                   (irq_take),
    .call_req                   (call_req),
    .call_target                (call_target),
    .ri_flag_write              (ri_flag_write),
    .program_counter            (program_counter),
    .config_register            (config_register),
    .interrupt_control_register (interrupt_control_register),
    .global_interrupt_enable    (global_interrupt_enable),
    .reset_instruction_flag     (reset_instruction_flag),
    .soft_reset                 (soft_reset),
    .busy                       (busy)
  );

  initial clk = 1'b0;
  always #10 clk = ~clk;

  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic chk(input logic [14:0] got, input logic [14:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic issue(input logic [13:0] op, input logic [7:0] w);
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word  = op;
    w_reg       = w;
    @(negedge clk);
    instr_valid = 1'b0;
  endtask : issue

  task automatic do_call(input logic [14:0] t);
    @(negedge clk);
    call_req    = 1'b1;
    call_target = t;
    @(negedge clk);
    call_req    = 1'b0;
  endtask : do_call

  task automatic do_irq;
    @(negedge clk);
    irq_take = 1'b1;
    @(negedge clk);
    irq_take = 1'b0;
  endtask : do_irq

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_config;
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word  = `CFE_OP_CONFIG_LOAD;
    w_reg       = 8'h4f;
    @(negedge clk);
    chk({7'h0, config_register}, 15'h004f, "config first");
    chk(program_counter, 15'h0001, "pc after load");
    w_reg = 8'h5a;
    @(negedge clk);
    instr_valid = 1'b0;
    chk({7'h0, config_register}, 15'h005a, "config back to back");
    chk({14'h0, global_interrupt_enable}, 15'h0000, "int enable untouched");
    $display("config load done");
  endtask : t_config

  task automatic t_return;
    do_call(15'h0100);
    do_call(15'h0200);
    chk(program_counter, 15'h0200, "pc after calls");
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word  = `CFE_OP_RETURN;
    @(negedge clk);
    chk(program_counter, 15'h0101, "pc after inner return");
    chk({14'h0, busy}, 15'h0001, "refill cycle");
    instr_word  = `CFE_OP_CONFIG_LOAD;
    w_reg       = 8'h11;
    @(negedge clk);
    instr_valid = 1'b0;
    chk({14'h0, busy}, 15'h0000, "busy one cycle");
    chk({7'h0, config_register}, 15'h005a, "word in refill ignored");
    issue(`CFE_OP_RETURN, 8'h00);
    chk(program_counter, 15'h0003, "pc after outer return");
    @(negedge clk);
    chk({14'h0, busy}, 15'h0000, "second refill over");
    $display("return done");
  endtask : t_return

  task automatic t_interrupt;
    do_irq();
    chk(program_counter, `CFE_INT_VECTOR, "vector");
    issue(`CFE_OP_RETURN_FROM_INT, 8'h00);
    chk(program_counter, 15'h0003, "pc after int return");
    chk({14'h0, global_interrupt_enable}, 15'h0001, "int enable set");
    chk({7'h0, interrupt_control_register}, 15'h0080, "int enable at bit 7");
    chk({14'h0, busy}, 15'h0001, "int return refill");
    @(negedge clk);
    chk({14'h0, busy}, 15'h0000, "int return two cycles");
    do_irq();
    chk({7'h0, interrupt_control_register}, 15'h0000, "int enable cleared by irq");
    $display("interrupt return done");
  endtask : t_interrupt

  task automatic t_soft_reset;
    issue(`CFE_OP_RETURN_FROM_INT, 8'h00);
    chk({14'h0, global_interrupt_enable}, 15'h0001, "int enable before reset");
    issue(`CFE_OP_SOFT_RESET, 8'h00);
    chk({14'h0, soft_reset}, 15'h0001, "reset pulse");
    chk({14'h0, reset_instruction_flag}, 15'h0000, "cause flag cleared");
    @(negedge clk);
    chk({14'h0, soft_reset}, 15'h0000, "pulse one cycle");
    chk(program_counter, `CFE_PC_RESET, "pc reset");
    chk({7'h0, config_register}, {7'h0, `CFE_CONFIG_RESET}, "config reset");
    chk({14'h0, global_interrupt_enable}, 15'h0000, "int enable reset");
    chk({14'h0, reset_instruction_flag}, 15'h0000, "cause flag kept");
    @(negedge clk);
    ri_flag_write = 1'b1;
    @(negedge clk);
    ri_flag_write = 1'b0;
    chk({14'h0, reset_instruction_flag}, 15'h0001, "flag rewritten");
    $display("soft reset done");
  endtask : t_soft_reset

  // ************************************************
  // Run control
  // ************************************************
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      $display("[FAIL] %0t timeout", $time);
      complete_run();
    end
  end

  initial begin
    rst           = 1'b1;
    instr_valid   = 1'b0;
    instr_word    = `CFE_OP_NO_OPERATION;
    w_reg         = 8'h00;
    irq_take      = 1'b0;
    call_req      = 1'b0;
    call_target   = 15'h0000;
    ri_flag_write = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk(program_counter, `CFE_PC_RESET, "pc at reset");
    chk({7'h0, config_register}, {7'h0, `CFE_CONFIG_RESET}, "config at reset");
    chk({14'h0, reset_instruction_flag}, 15'h0001, "flag at reset");
    t_config();
    t_return();
    t_interrupt();
    t_soft_reset();
    complete_run();
  end
endmodule : tb

`default_nettype wire
